// File: tcv_pkg.sv
// package: register map, field layouts and carrier types for the channel value block
// How it works
// RL1: each channel's value pair holds the captured counter in capture mode, else the compare value.
// RL2: the value registers have no reset, so nothing may assume their contents after reset.
// RL3: in capture mode a high byte read blocks captures on that channel until its low byte is read.
// RL4: in compare mode a high byte write blocks matches and the flag until the low byte is written.
// RL5: the flag sets on an active capture edge, or when the counter equals the compare value.
// RL6: matches use only a complete sixteen-bit value, never a half-written one.
`default_nettype none
package tcv_pkg;
  localparam int          NUM_CH       = 6;
  localparam logic [7:0]  ADDR_CH0_H   = 8'h27;
  localparam logic [7:0]  ADDR_CH0_L   = 8'h28;
  localparam logic [7:0]  ADDR_CH1_H   = 8'h2A;
  localparam logic [7:0]  ADDR_CH1_L   = 8'h2B;
  localparam logic [7:0]  ADDR_CH2_H   = 8'h2D;
  localparam logic [7:0]  ADDR_CH2_L   = 8'h2E;
  localparam logic [7:0]  ADDR_CH3_H   = 8'h30;
  localparam logic [7:0]  ADDR_CH3_L   = 8'h31;
  localparam logic [7:0]  ADDR_CH4_H   = 8'h33;
  localparam logic [7:0]  ADDR_CH4_L   = 8'h34;
  localparam logic [7:0]  ADDR_CH5_H   = 8'h36;
  localparam logic [7:0]  ADDR_CH5_L   = 8'h37;
  localparam logic [7:0]  ADDR_IRQ_ST  = 8'h40;
  localparam logic [7:0]  ADDR_IRQ_CLR = 8'h41;
  localparam logic [7:0]  ADDR_IRQ_EN  = 8'h42;
  localparam logic [7:0]  ADDR_FLAGS   = 8'h43;
  localparam logic [7:0]  RD_UNMAPPED  = 8'h00;
  localparam logic [5:0]  FLAG_RESET   = 6'h00;

  typedef logic [7:0] tcv_byte_t;

  // per channel controls and events from the rest of the timer
  typedef struct packed {
    logic ms_b;
    logic ms_a;
    logic edge_evt;
  } tcv_chan_in_t;

  // per channel view of the value register
  typedef struct packed {
    logic [15:0] value;
    logic        cap_blocked;
    logic        cmp_blocked;
    logic        flag;
  } tcv_chan_out_t;

  typedef struct packed {
    logic       wr_high;
    logic       wr_low;
    logic       rd_high;
    logic       rd_low;
    logic       flag_clr;
    tcv_byte_t  wdata;
  } tcv_chan_acc_t;
endpackage : tcv_pkg
`default_nettype wire

// File: tcv_value_mem.sv
// 16-bit value storage for one channel, no reset on the data
`default_nettype none
module tcv_value_mem (
  input  wire logic        clk,
  input  wire logic        we_high,
  input  wire logic        we_low,
  input  wire logic        we_word,
  input  wire logic [7:0]  wbyte,
  input  wire logic [15:0] wword,
  output var  logic [15:0] value
);
  // no reset here on purpose: contents undefined after reset  RL2
  always_ff @(posedge clk) begin
    if (we_word) begin
      value <= wword; // RL1
    end else begin
      if (we_high) begin
        value[15:8] <= wbyte;
      end
      if (we_low) begin
        value[7:0] <= wbyte;
      end
    end
  end
endmodule : tcv_value_mem
`default_nettype wire

// File: tcv_channel.sv
// one channel: byte interlocks, capture, compare and flag
`default_nettype none
module tcv_channel (
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  input  wire logic [15:0]            counter,
  input  wire tcv_pkg::tcv_chan_in_t  cin,
  input  wire tcv_pkg::tcv_chan_acc_t acc,
  output var  tcv_pkg::tcv_chan_out_t cout
);
  typedef struct packed {
    logic cap_blocked;
    logic cmp_blocked;
    logic flag;
  } tcv_chst_t;

  tcv_chst_t   st;
  tcv_chst_t   next_st;
  logic [15:0] value;
  logic        capture_mode;
  logic        do_capture;
  logic        match;

  assign capture_mode = ~cin.ms_b & ~cin.ms_a;
  assign do_capture   = capture_mode & cin.edge_evt & ~st.cap_blocked; // RL3
  // half-written compare word stays masked by cmp_blocked until the low byte lands  RL6
  assign match        = ~capture_mode & ~st.cmp_blocked & (counter == value); // RL4

  always_comb begin
    next_st = st;
    if (!capture_mode) begin
      next_st.cap_blocked = 1'b0;
    end else if (acc.rd_high) begin
      next_st.cap_blocked = 1'b1; // RL3
    end else if (acc.rd_low) begin
      next_st.cap_blocked = 1'b0; // RL3
    end
    if (capture_mode) begin
      next_st.cmp_blocked = 1'b0;
    end else if (acc.wr_high) begin
      next_st.cmp_blocked = 1'b1; // RL4
    end else if (acc.wr_low) begin
      next_st.cmp_blocked = 1'b0; // RL4
    end
    if (acc.flag_clr) begin
      next_st.flag = 1'b0;
    end
    if (do_capture || match) begin
      next_st.flag = 1'b1; // RL5
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  tcv_value_mem u_mem (
    .clk     (clk),
    .we_high (acc.wr_high & ~do_capture),
    .we_low  (acc.wr_low & ~do_capture),
    .we_word (do_capture),
    .wbyte   (acc.wdata),
    .wword   (counter),
    .value   (value)
  );

  assign cout.value       = value;
  assign cout.cap_blocked = st.cap_blocked;
  assign cout.cmp_blocked = st.cmp_blocked;
  assign cout.flag        = st.flag;

  a_blocked_no_cap: assert property (@(posedge clk) disable iff (!arst_n) // RL3
    st.cap_blocked && capture_mode && cin.edge_evt && !acc.wr_high && !acc.wr_low
      |=> value == $past(value)) else $error("capture while blocked");
  a_cmp_suppress: assert property (@(posedge clk) disable iff (!arst_n) // RL4
    st.cmp_blocked && !capture_mode && !st.flag
      |=> !st.flag) else $error("flag while compare blocked");
  a_match_flag: assert property (@(posedge clk) disable iff (!arst_n)
    match |=> st.flag) else $error("match did not set flag"); // RL5
  a_capture_loads: assert property (@(posedge clk) disable iff (!arst_n)
    do_capture |=> value == $past(counter)) else $error("capture value wrong"); // RL1
  a_rdhigh_blocks: assert property (@(posedge clk) disable iff (!arst_n) // RL3
    capture_mode && acc.rd_high |=> st.cap_blocked || !capture_mode)
    else $error("high read did not block");
  a_wrhigh_blocks: assert property (@(posedge clk) disable iff (!arst_n) // RL4
    !capture_mode && acc.wr_high |=> st.cmp_blocked || capture_mode)
    else $error("high write did not block");
  a_cap_flag: assert property (@(posedge clk) disable iff (!arst_n)
    do_capture |=> st.flag) else $error("capture did not set flag"); // RL5
endmodule : tcv_channel
`default_nettype wire

// File: tcv_top.sv
// top: register port, six channels and interrupt logic
//
// The implementer's own choice: strobed register access.
`default_nettype none
module tcv_top (
  input  wire logic                    clk,
  input  wire logic                    arst_n,
  input  wire logic [7:0]              addr,
  input  wire logic [7:0]              wdata,
  input  wire logic                    wr,
  input  wire logic                    rd,
  output var  logic [7:0]              rdata,
  input  wire logic [15:0]             counter,
  input  wire logic [5:0]              ms_b,
  input  wire logic [5:0]              ms_a,
  input  wire logic [5:0]              edge_pin_evt,
  output var  logic [5:0]              channel_event_flag,
  output var  logic                    irq
);
  typedef struct packed {
    logic [7:0] rdata;
    logic [5:0] irq_st;
    logic [5:0] irq_en;
    logic [5:0] flag_q;
    logic       irq;
    logic [5:0] evt_s1;
    logic [5:0] evt_s2;
    logic [5:0] evt_s3;
  } tcv_top_t;

  localparam logic [7:0] HI_ADDR [tcv_pkg::NUM_CH] = '{tcv_pkg::ADDR_CH0_H,
    tcv_pkg::ADDR_CH1_H, tcv_pkg::ADDR_CH2_H, tcv_pkg::ADDR_CH3_H,
    tcv_pkg::ADDR_CH4_H, tcv_pkg::ADDR_CH5_H};
  localparam logic [7:0] LO_ADDR [tcv_pkg::NUM_CH] = '{tcv_pkg::ADDR_CH0_L,
    tcv_pkg::ADDR_CH1_L, tcv_pkg::ADDR_CH2_L, tcv_pkg::ADDR_CH3_L,
    tcv_pkg::ADDR_CH4_L, tcv_pkg::ADDR_CH5_L};

  tcv_top_t               s;
  tcv_top_t               next_s;
  tcv_pkg::tcv_chan_out_t cout [tcv_pkg::NUM_CH];
  logic [5:0]             flag_now;
  logic [5:0]             edge_evt;

  // edge events come from pins; the second and third stages feed the edge detector
  assign edge_evt = s.evt_s2 & ~s.evt_s3;

  for (genvar i = 0; i < tcv_pkg::NUM_CH; i++) begin : g_ch
    tcv_pkg::tcv_chan_in_t  cin;
    tcv_pkg::tcv_chan_acc_t acc;
    assign cin.ms_b     = ms_b[i];
    assign cin.ms_a     = ms_a[i];
    assign cin.edge_evt = edge_evt[i];
    assign acc.wr_high  = wr && (addr == HI_ADDR[i]);
    assign acc.wr_low   = wr && (addr == LO_ADDR[i]);
    assign acc.rd_high  = rd && (addr == HI_ADDR[i]);
    assign acc.rd_low   = rd && (addr == LO_ADDR[i]);
    assign acc.flag_clr = wr && (addr == tcv_pkg::ADDR_FLAGS) && wdata[i];
    assign acc.wdata    = wdata;
    assign flag_now[i]  = cout[i].flag;
    tcv_channel u_ch (
      .clk     (clk),
      .arst_n  (arst_n),
      .counter (counter),
      .cin     (cin),
      .acc     (acc),
      .cout    (cout[i])
    );
  end

  always_comb begin
    next_s        = s;
    next_s.evt_s1 = edge_pin_evt;
    next_s.evt_s2 = s.evt_s1;
    next_s.evt_s3 = s.evt_s2;
    next_s.flag_q = flag_now;
    next_s.rdata  = tcv_pkg::RD_UNMAPPED;
    if (rd) begin
      for (int i = 0; i < tcv_pkg::NUM_CH; i++) begin
        if (addr == HI_ADDR[i]) begin
          next_s.rdata = cout[i].value[15:8];
        end
        if (addr == LO_ADDR[i]) begin
          next_s.rdata = cout[i].value[7:0];
        end
      end
      case (addr)
        tcv_pkg::ADDR_IRQ_ST: next_s.rdata = {2'h0, s.irq_st};
        tcv_pkg::ADDR_IRQ_EN: next_s.rdata = {2'h0, s.irq_en};
        tcv_pkg::ADDR_FLAGS:  next_s.rdata = {2'h0, flag_now};
        default: ;
      endcase
    end
    if (wr && addr == tcv_pkg::ADDR_IRQ_EN) begin
      next_s.irq_en = wdata[5:0];
    end
    if (wr && addr == tcv_pkg::ADDR_IRQ_CLR) begin
      next_s.irq_st = s.irq_st & ~wdata[5:0];
    end
    // new flag rising wins over a clear in the same cycle
    next_s.irq_st = next_s.irq_st | (flag_now & ~s.flag_q);
    next_s.irq    = |(next_s.irq_st & next_s.irq_en);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rdata              = s.rdata;
  assign channel_event_flag = s.flag_q;
  assign irq                = s.irq;
endmodule : tcv_top
`default_nettype wire

// File: timer_channel_value_registers_bench.sv
// bench: register port sequences for capture, compare and interrupt behaviour
`default_nettype none
module timer_channel_value_registers_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk          = 1'b0;
  logic        arst_n       = 1'b0;
  logic [7:0]  addr         = 8'h00;
  logic [7:0]  wdata        = 8'h00;
  logic        wr           = 1'b0;
  logic        rd           = 1'b0;
  logic [7:0]  rdata;
  logic [15:0] counter      = 16'h0000;
  logic [5:0]  ms_b         = 6'h00;
  logic [5:0]  ms_a         = 6'h00;
  logic [5:0]  edge_pin_evt = 6'h00;
  logic [5:0]  channel_event_flag;
  logic        irq;
  int          errors       = 0;
  int          checked      = 0;

  tcv_top u_tcv_top (
    .clk                (clk),
    .arst_n             (arst_n),
    .addr               (addr),
    .wdata              (wdata),
    .wr                 (wr),
    .rd                 (rd),
    .rdata              (rdata),
    .counter            (counter),
    .ms_b               (ms_b),
    .ms_a               (ms_a),
    .edge_pin_evt       (edge_pin_evt),
    .channel_event_flag (channel_event_flag),
    .irq                (irq)
  );

  always #20 clk = ~clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cycles

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  task automatic set_counter(input logic [15:0] v);
    @(posedge clk);
    counter <= v;
  endtask : set_counter

  task automatic pulse_edge;
    @(posedge clk);
    edge_pin_evt[0] <= 1'b1;
    repeat (6) @(posedge clk);
    edge_pin_evt[0] <= 1'b0;
    cycles(3);
  endtask : pulse_edge

  task automatic print_verdict;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  initial begin
    #200000;
    errors++;
    print_verdict();
  end

  initial begin
    logic [7:0] d;
    cycles(20);
    check(rdata, 8'h00);
    check(channel_event_flag, 6'h00);
    check(irq, 1'b0);
    @(posedge clk);
    arst_n <= 1'b1;
    // capture mode on channel 0
    counter <= 16'hA5C3;
    pulse_edge();
    check(channel_event_flag[0], 1'b1);
    rd_reg(tcv_pkg::ADDR_CH0_H, d);
    check(d, 8'hA5);
    set_counter(16'h0F0F);
    pulse_edge();
    rd_reg(tcv_pkg::ADDR_CH0_L, d);
    check(d, 8'hC3);
    pulse_edge();
    rd_reg(tcv_pkg::ADDR_CH0_H, d);
    check(d, 8'h0F);
    rd_reg(tcv_pkg::ADDR_CH0_L, d);
    check(d, 8'h0F);
    wr_reg(tcv_pkg::ADDR_FLAGS, 8'h01);
    cycles(3);
    check(channel_event_flag, 6'h00);
    // compare mode on channel 1
    @(posedge clk);
    ms_a[1] <= 1'b1;
    wr_reg(tcv_pkg::ADDR_CH1_H, 8'h12);
    wr_reg(tcv_pkg::ADDR_CH1_L, 8'h34);
    rd_reg(tcv_pkg::ADDR_CH1_H, d);
    check(d, 8'h12);
    rd_reg(tcv_pkg::ADDR_CH1_L, d);
    check(d, 8'h34);
    set_counter(16'h1234);
    cycles(4);
    check(channel_event_flag, 6'h02);
    set_counter(16'h0000);
    wr_reg(tcv_pkg::ADDR_FLAGS, 8'h02);
    wr_reg(tcv_pkg::ADDR_CH1_H, 8'h56);
    set_counter(16'h5634);
    cycles(4);
    set_counter(16'h1234);
    cycles(4);
    check(channel_event_flag, 6'h00);
    wr_reg(tcv_pkg::ADDR_CH1_L, 8'h78);
    set_counter(16'h5634);
    cycles(4);
    check(channel_event_flag, 6'h00);
    set_counter(16'h5678);
    cycles(4);
    check(channel_event_flag, 6'h02);
    // compare mode on channel 2, selected through ms_b
    @(posedge clk);
    ms_b[2] <= 1'b1;
    wr_reg(tcv_pkg::ADDR_CH2_H, 8'h9A);
    wr_reg(tcv_pkg::ADDR_CH2_L, 8'hBC);
    set_counter(16'h9ABC);
    cycles(4);
    check(channel_event_flag, 6'h06);
    set_counter(16'h0000);
    // interrupt enable, status and clear
    wr_reg(tcv_pkg::ADDR_IRQ_EN, 8'h02);
    cycles(3);
    check(irq, 1'b1);
    rd_reg(tcv_pkg::ADDR_IRQ_ST, d);
    check(d[1], 1'b1);
    wr_reg(tcv_pkg::ADDR_IRQ_CLR, 8'h02);
    cycles(3);
    check(irq, 1'b0);
    rd_reg(8'h00, d);
    check(d, tcv_pkg::RD_UNMAPPED);
    print_verdict();
  end
endmodule : timer_channel_value_registers_bench
`default_nettype wire
